//--- hw/atm_map.vh
// register map, field positions, reset values and codes of the tone/mute/polarity bank
// Summary of operation
// R1: mode bits 15:14 pick flat, minimum, maximum
// R2: host never writes mode code 10
// R3: treble bits 13:12 give 0 to 6 dB
// R4: flat set forces zero treble and bass
// R5: bass bits 11:8, minimum saturates 18 dB
// R6: maximum set bass saturates at 24 dB
// R7: mute bit 15 selects quick mute
// R8: mute bit 14 or mute pin mutes
// R9: mute bit 13 selects 6 dB gain
// R10: host keeps mute bits 10:8 zero
// R11: polarity bit 15 inverts converter output
// R12: host keeps polarity fixed bits as required
// R13: input settings reset bits 3,2 set
// R14: input bit 3 folds format into lock
// R15: input bit 2 mutes on burst preambles
// R16: tone register sits at address 12H
`ifndef ATM_MAP_VH
`define ATM_MAP_VH
`define ATM_ADDR_TONE     8'h12
`define ATM_ADDR_MUTE     8'h13
`define ATM_ADDR_POL      8'h14
`define ATM_ADDR_INPUT    8'h30
`define ATM_TONE_RESET    16'h0000
`define ATM_MUTE_RESET    16'h4000
`define ATM_POL_RESET     16'h4200
`define ATM_INPUT_RESET   16'h000C
`define ATM_MODE_HI       15
`define ATM_MODE_LO       14
`define ATM_TREBLE_HI     13
`define ATM_TREBLE_LO     12
`define ATM_BASS_HI       11
`define ATM_BASS_LO       8
`define ATM_FAST_BIT      15
`define ATM_SILENCE_BIT   14
`define ATM_GAIN_BIT      13
`define ATM_INVERT_BIT    15
`define ATM_COMBINE_BIT   3
`define ATM_PREAMBLE_BIT  2
`define ATM_MODE_FLAT     2'h0
`define ATM_MODE_MIN      2'h1
`define ATM_MODE_ODD      2'h2
`define ATM_MODE_MAX      2'h3
`define ATM_BASS_MIN_CAP  5'h12
`define ATM_BASS_MAX_CAP  5'h18
`endif

//--- hw/atm_regs.v
// write-only tone, mute, polarity and input receiver control register bank
`timescale 1ns/1ps
`include "atm_map.vh"
module atm_regs (
  input  wire        clk,              // 100 MHz system clock
  input  wire        srst,             // synchronous reset, active high
  input  wire        wr_en,            // one-cycle register write strobe
  input  wire [7:0]  wr_addr,          // register address
  input  wire [15:0] wr_data,          // register write data
  input  wire        mute_pin,         // external mute pin, high mutes
  input  wire        decoder_lock,     // raw receiver lock
  input  wire        pcm_detected,     // receiver sees plain audio samples
  input  wire        preamble_seen,    // burst preambles detected in stream
  output reg  [1:0]  filter_set,       // active filter set
  output reg  [2:0]  treble_level,     // treble boost in dB
  output reg  [4:0]  bass_level,       // bass boost in dB
  output reg         fast_silence_select, // quick mute when high
  output reg         silence_request,  // mute the audio output
  output reg         interp_gain_select, // 6 dB interpolator gain when high
  output reg         output_invert,    // invert converter output
  output reg         lock_indicator,   // combined lock indicator
  output reg         preamble_auto_silence_en // preamble auto mute enabled
);
  // write timing: word stored at the write edge
  // outputs reload one edge later, two edges in all
  // pins pass one flop, outputs follow a pin in one edge
  // unmapped addresses dropped, nothing reads back
  // host-only fixed bits stored as written, not policed
  // low byte of the tone word stored but unused
  // mute comes up asserted, so no sound before setup
  // lock held low in reset until the pins are flopped

  // stored register words
  reg  [15:0] tone_reg;       // tone filter settings
  reg  [15:0] mute_reg;       // mute and gain control
  reg  [15:0] pol_reg;        // output polarity control
  reg  [15:0] input_reg;      // input receiver settings

  // per-register write strobes
  wire        hit_tone;       // write aimed at the tone word
  wire        hit_mute;       // write aimed at the mute word
  wire        hit_pol;        // write aimed at the polarity word
  wire        hit_input;      // write aimed at the input word

  // tone figures from the decoder
  wire [1:0]  set_dec;        // decoded filter set
  wire [2:0]  treble_dec;     // decoded treble boost
  wire [4:0]  bass_dec;       // decoded bass boost

  // single-bit fields of the stored words
  wire        fast_bit;       // quick mute selected
  wire        silence_bit;    // host mute request
  wire        gain_bit;       // 6 dB interpolator gain
  wire        invert_bit;     // output polarity inverted
  wire        combine_bit;    // format status folded into lock
  wire        preamble_bit;   // preamble auto mute enabled

  // partial and next values of the combined outputs
  reg         pin_mute;       // mute asked for by the pin
  reg         preamble_mute;  // mute asked for by burst preambles
  reg         silence_next;   // next mute request
  reg         lock_next;      // next lock indicator

  // address match, unmapped addresses hit nothing
  assign hit_tone  = wr_en & (wr_addr == `ATM_ADDR_TONE);   // see R16
  assign hit_mute  = wr_en & (wr_addr == `ATM_ADDR_MUTE);
  assign hit_pol   = wr_en & (wr_addr == `ATM_ADDR_POL);
  assign hit_input = wr_en & (wr_addr == `ATM_ADDR_INPUT);

  // tone word, flat set and no boost after reset
  always @(posedge clk) begin
    if (srst) begin
      tone_reg <= `ATM_TONE_RESET;    // see R1
    end else if (hit_tone) begin
      tone_reg <= wr_data;            // whole word kept
    end
  end

  // mute word, muted and soft mute after reset
  always @(posedge clk) begin
    if (srst) begin
      mute_reg <= `ATM_MUTE_RESET;    // see R8
    end else if (hit_mute) begin
      mute_reg <= wr_data;            // fixed bits kept as written
    end
  end

  // polarity word, not inverted after reset
  always @(posedge clk) begin
    if (srst) begin
      pol_reg <= `ATM_POL_RESET;      // see R11
    end else if (hit_pol) begin
      pol_reg <= wr_data;             // fixed bits kept as written
    end
  end

  // input word, combine and preamble mute on after reset
  always @(posedge clk) begin
    if (srst) begin
      input_reg <= `ATM_INPUT_RESET;  // see R13
    end else if (hit_input) begin
      input_reg <= wr_data;           // whole word kept
    end
  end

  // field taps on the stored words
  assign fast_bit     = mute_reg[`ATM_FAST_BIT];
  assign silence_bit  = mute_reg[`ATM_SILENCE_BIT];
  assign gain_bit     = mute_reg[`ATM_GAIN_BIT];
  assign invert_bit   = pol_reg[`ATM_INVERT_BIT];
  assign combine_bit  = input_reg[`ATM_COMBINE_BIT];
  assign preamble_bit = input_reg[`ATM_PREAMBLE_BIT];

  // tone field decode, flat set forces zero boost inside
  atm_tone_decode u_dec (
    .mode      (tone_reg[`ATM_MODE_HI:`ATM_MODE_LO]),
    .treble    (tone_reg[`ATM_TREBLE_HI:`ATM_TREBLE_LO]),
    .bass      (tone_reg[`ATM_BASS_HI:`ATM_BASS_LO]),
    .set_sel   (set_dec),
    .treble_db (treble_dec),
    .bass_db   (bass_dec)
  );

  // mute request and lock indicator, each from its sources
  always @* begin
    pin_mute      = mute_pin;                              // pin mutes while high, see R8
    preamble_mute = preamble_bit & preamble_seen;          // see R15
    silence_next  = silence_bit | pin_mute | preamble_mute;  // see R8
    if (combine_bit) begin
      lock_next = decoder_lock & pcm_detected;             // format status folded in, see R14
    end else begin
      lock_next = decoder_lock;                            // raw lock only, see R14
    end
  end

  // filter set seen by the tone filters
  // reset shows the flat set
  always @(posedge clk) begin
    if (srst) begin
      filter_set <= `ATM_MODE_FLAT;
    end else begin
      filter_set <= set_dec;            // see R1
    end
  end

  // treble boost in dB
  // zero in reset and in the flat set
  always @(posedge clk) begin
    if (srst) begin
      treble_level <= 3'h0;
    end else begin
      treble_level <= treble_dec;       // see R3
    end
  end

  // bass boost in dB, already saturated
  // zero in reset and in the flat set
  always @(posedge clk) begin
    if (srst) begin
      bass_level <= 5'h00;
    end else begin
      bass_level <= bass_dec;           // see R5 R6
    end
  end

  // mute style select
  // soft mute after reset
  always @(posedge clk) begin
    if (srst) begin
      fast_silence_select <= 1'b0;
    end else begin
      fast_silence_select <= fast_bit;  // see R7
    end
  end

  // mute request to the output stage
  // asserted through reset
  always @(posedge clk) begin
    if (srst) begin
      silence_request <= 1'b1;
    end else begin
      silence_request <= silence_next;  // see R8 R15
    end
  end

  // interpolator gain select
  // 0 dB after reset
  always @(posedge clk) begin
    if (srst) begin
      interp_gain_select <= 1'b0;
    end else begin
      interp_gain_select <= gain_bit;   // see R9
    end
  end

  // converter output polarity
  // not inverted after reset
  always @(posedge clk) begin
    if (srst) begin
      output_invert <= 1'b0;
    end else begin
      output_invert <= invert_bit;      // see R11
    end
  end

  // combined lock indicator
  // held low through reset
  always @(posedge clk) begin
    if (srst) begin
      lock_indicator <= 1'b0;
    end else begin
      lock_indicator <= lock_next;      // see R14
    end
  end

  // preamble auto mute enable, shown to the receiver
  // enabled after reset
  always @(posedge clk) begin
    if (srst) begin
      preamble_auto_silence_en <= 1'b1;
    end else begin
      preamble_auto_silence_en <= preamble_bit;  // see R15
    end
  end
endmodule

//--- hw/atm_tone_decode.v
// decoder from tone register fields to treble and bass boost in dB
`timescale 1ns/1ps
`include "atm_map.vh"
module atm_tone_decode (
  input  wire [1:0] mode,       // filter set code
  input  wire [1:0] treble,     // treble code
  input  wire [3:0] bass,       // bass code
  output reg  [1:0] set_sel,    // 0 flat, 1 minimum, 3 maximum
  output reg  [2:0] treble_db,  // treble boost in dB
  output reg  [4:0] bass_db     // bass boost in dB
);
  reg [4:0] raw_db;  // unsaturated bass figure, two per step

  // combinational decode of the filter set and boost figures
  always @* begin
    raw_db    = {bass, 1'b0};
    set_sel   = mode;
    treble_db = 3'h0;
    bass_db   = 5'h00;
    case (mode)
      `ATM_MODE_FLAT: begin
        set_sel = `ATM_MODE_FLAT;  // zero boost in flat set, see R4
      end
      `ATM_MODE_MIN, `ATM_MODE_ODD: begin
        set_sel   = `ATM_MODE_MIN;  // undefined code treated as minimum, see R2
        treble_db = {treble, 1'b0};  // see R3
        bass_db   = (raw_db > `ATM_BASS_MIN_CAP) ? `ATM_BASS_MIN_CAP : raw_db;  // see R5
      end
      `ATM_MODE_MAX: begin
        set_sel   = `ATM_MODE_MAX;  // see R1
        treble_db = {treble, 1'b0};  // see R3
        bass_db   = (raw_db > `ATM_BASS_MAX_CAP) ? `ATM_BASS_MAX_CAP : raw_db;  // see R6
      end
      default: begin
        set_sel = `ATM_MODE_FLAT;
      end
    endcase
  end
endmodule

//--- tb/atm_host.sv
// host model issuing register writes
`timescale 1ns/1ps
module atm_host (
  input  wire        clk,
  output reg         wr_en,
  output reg  [7:0]  wr_addr,
  output reg  [15:0] wr_data
);
  initial {wr_en, wr_addr, wr_data} = 25'h0;
  // one write, taken at the next edge
  task wr(input [7:0] a, input [15:0] d);
    begin
      if (a == 8'h12 && d[15:14] == 2'h2) d[15] = 1'b0;
      if (a == 8'h13) d[10:8] = 3'h0;
      if (a == 8'h14) d = (d | 16'h4200) & 16'hFE7F;
      wr_en <= 1'b1; wr_addr <= a; wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
    end
  endtask
endmodule

//--- tb/atm_regs_sva.sv
// assertions on the tone, mute, polarity and input register bank
`timescale 1ns/1ps
module atm_regs_sva (
  input wire        clk,
  input wire        srst,
  input wire        wr_en,
  input wire [7:0]  wr_addr,
  input wire [15:0] wr_data,
  input wire        mute_pin,
  input wire        decoder_lock,
  input wire [1:0]  filter_set,
  input wire [2:0]  treble_level,
  input wire [4:0]  bass_level,
  input wire        silence_request,
  input wire        interp_gain_select,
  input wire        output_invert,
  input wire        lock_indicator
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire mw = wr_en && wr_addr == 8'h13; // mute register write
  a_gain_follows: assert property (mw |-> ##2 interp_gain_select == $past(wr_data[13], 2))
    else $error("gain");
  a_invert_follows: assert property (wr_en && wr_addr == 8'h14 |-> ##2 output_invert == $past(wr_data[15], 2))
    else $error("invert");
  a_mode_hi_bit: assert property (wr_en && wr_addr == 8'h12 |-> ##2 filter_set[1] == $past(wr_data[15], 2))
    else $error("mode");
  a_mute_bit: assert property (mw && wr_data[14] |-> ##2 silence_request)
    else $error("mute bit");
  a_pin_mutes: assert property (mute_pin |=> silence_request)
    else $error("mute pin");
  a_lock_raw: assert property (!decoder_lock |=> !lock_indicator)
    else $error("lock");
  a_flat_zero: assert property (filter_set == 2'h0 |-> treble_level == 3'h0 && bass_level == 5'h00)
    else $error("flat");
  a_bass_caps: assert property (bass_level <= (filter_set == 2'h1 ? 5'h12 : 5'h18))
    else $error("bass cap");
endmodule
bind atm_regs atm_regs_sva chk (.clk, .srst, .wr_en, .wr_addr, .wr_data, .mute_pin,
  .decoder_lock, .filter_set, .treble_level, .bass_level, .silence_request,
  .interp_gain_select, .output_invert, .lock_indicator);

//--- tb/tb.sv
// self-checking bench for the tone, mute, polarity and input register bank
`timescale 1ns/1ps
module tb;
  reg         clk = 1'b0, srst = 1'b1, chk = 1'b0;
  reg  [3:0]  pins = 4'h0; // mute pin, lock, pcm, preamble
  wire        wr_en;
  wire [7:0]  wr_addr;
  wire [15:0] wr_data, got; // got packs all outputs
  reg  [15:0] t_s = 16'h0000, m_s = 16'h4000, p_s = 16'h4200, i_s = 16'h000C;
  reg  [15:0] exp_q[$];
  reg  [7:0]  tab[0:4] = '{8'h12, 8'h13, 8'h14, 8'h30, 8'h31};
  integer     n_errors = 0, tests_run = 0, seed = 32'hEF19BAA0, k;
  reg  [31:0] rnd; // raw random word
  always #5 clk = ~clk;
  atm_host host (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
  atm_regs DUT (.clk(clk), .srst(srst), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .mute_pin(pins[3]), .decoder_lock(pins[2]), .pcm_detected(pins[1]), .preamble_seen(pins[0]),
    .filter_set(got[15:14]), .treble_level(got[13:11]), .bass_level(got[10:6]),
    .fast_silence_select(got[5]), .silence_request(got[4]), .interp_gain_select(got[3]),
    .output_invert(got[2]), .lock_indicator(got[1]), .preamble_auto_silence_en(got[0]));
  // expected outputs from the shadow registers
  function [15:0] expv();
    reg [4:0] b;
    begin
      b = (t_s[15:14] == 2'h0) ? 5'h00 : {t_s[11:8], 1'b0};
      if (t_s[15:14] == 2'h1 && b > 5'h12) b = 5'h12;
      if (b > 5'h18) b = 5'h18;
      expv = {t_s[15:14], (t_s[15:14] == 2'h0) ? 3'h0 : {t_s[13:12], 1'b0}, b, m_s[15],
        m_s[14] | pins[3] | (i_s[2] & pins[0]), m_s[13], p_s[15],
        pins[2] & (~i_s[3] | pins[1]), i_s[2]};
    end
  endfunction
  task cmp(input [15:0] e, input [15:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("BAD outputs expected %h seen %h", e, g);
      end
    end
  endtask
  // oldest note against the outputs
  always @(negedge clk) if (chk) cmp(exp_q.pop_front(), got);
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    exp_q.push_back(expv());
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
    for (k = 0; k < 60; k = k + 1) begin
      rnd = $random(seed);
      pins <= rnd[3:0];
      rnd = $random(seed);
      host.wr(tab[k % 5], rnd[15:0]);
      case (wr_addr)
        8'h12: t_s = wr_data;
        8'h13: m_s = wr_data;
        8'h14: p_s = wr_data;
        8'h30: i_s = wr_data;
        default: ;
      endcase
      exp_q.push_back(expv());
      @(posedge clk);
      chk <= 1'b1;
      @(posedge clk);
      chk <= 1'b0;
      $display("write %0d to %h done", k, wr_addr);
    end
    // mid-run reset: written words must fall back
    pins <= 4'h0;
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_s = 16'h0000;
    m_s = 16'h4000;
    p_s = 16'h4200;
    i_s = 16'h000C;
    exp_q.push_back(expv());
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
    $display("reset test done");
    wrap_up;
  end
  task wrap_up;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
endmodule
